// ==== sapc_defs.vh ====
`ifndef SAPC_DEFS_VH
`define SAPC_DEFS_VH

// ==========================================================
// Widths
`define SAPC_RES_W 14
`define SAPC_BYTE_W 8
`define SAPC_CNT_W 8

// ==========================================================
// Timing: conversion time in ns, clock period in ns
`define SAPC_T_CONV_NS 4700
`define SAPC_CLK_NS 40
// Longest time rounds down
`define SAPC_CONV_CYC (`SAPC_T_CONV_NS / `SAPC_CLK_NS)

// ==========================================================
// Result reset value and SAR start mask
`define SAPC_RES_RST 14'h0000
`define SAPC_SAR_TOP 14'h2000
`define SAPC_CNT_ZERO 8'h00
`define SAPC_HI_PAD 2'h0

`endif

// ==== sapc_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser for one pin
module sapc_sync
(
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	// Pin and synchronised level
	input wire pin,
	output reg sync_q
);

reg meta_q;

// Only sync_q reads meta_q
always @(posedge mclk)
begin
	if (!rst_b)
	begin
		meta_q <= 1'b1;
		sync_q <= 1'b1;
	end
	else
	begin
		meta_q <= pin;
		sync_q <= meta_q;
	end
end

endmodule
`default_nettype wire

// ==== sapc_top.v ====
// What this block does
// R1 - First strobe fall with select low wakes device into acquisition.
// R2 - Second strobe fall ends acquisition and starts conversion.
// R3 - Third strobe fall with select high drives result on bus.
// R4 - Reset pin high resets the whole device.
// R5 - Result is 14 bits; byte variant shares one eight-line bus.
// R6 - High-byte select 1 gives high byte, 0 gives low byte.
// R7 - Select at second fall: high shuts reference down, low keeps it.
// R8 - End-of-conversion output goes low when conversion finishes.
// R9 - Bit 13 is MSB; high byte holds bits 13..8, top two zero.
// R10 - Data outputs stay undriven unless presenting a result.
`include "sapc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module sapc_top
(
	// Clock and system reset
	input wire mclk,
	input wire rst_b,
	// Host pins
	input wire dev_reset,
	input wire conv_strobe_b,
	input wire read_conv_sel,
	input wire high_byte_select,
	// Comparator from the analog core
	input wire cmp_in,
	// Status and power pins
	output reg eoc_b_q,
	output reg ref_pwr_q,
	output reg acq_q,
	// Wide data bus, enable low drives
	output reg [`SAPC_RES_W-1:0] result_bits_q,
	output reg [`SAPC_RES_W-1:0] result_oe_b_q,
	// Byte bus, enable low drives
	output reg [`SAPC_BYTE_W-1:0] byte_bus_q,
	output reg [`SAPC_BYTE_W-1:0] byte_oe_b_q
);

// ==========================================================
// States
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_ACQ = 5'h02;
localparam [4:0] ST_CONV = 5'h04;
localparam [4:0] ST_DONE = 5'h08;
localparam [4:0] ST_READ = 5'h10;

// Whole cycles of the conversion time, cut to the counter width
localparam integer CONV_CYC_N = `SAPC_CONV_CYC;
localparam [`SAPC_CNT_W-1:0] CONV_CYC = CONV_CYC_N[`SAPC_CNT_W-1:0];
localparam [`SAPC_CNT_W-1:0] CNT_ONE = 8'h01;

wire strobe_s;
wire sel_s;
wire hbs_s;
wire rst_pin_s;
reg strobe_prev_q;
wire strobe_fall;
reg [4:0] state_q;
reg [4:0] state_d;
reg shut_q;
reg [`SAPC_CNT_W-1:0] cnt_q;
reg [`SAPC_RES_W-1:0] sar_q;
reg [`SAPC_RES_W-1:0] bit_q;
reg [`SAPC_RES_W-1:0] res_q;
wire soft_rst;
wire [`SAPC_BYTE_W-1:0] hi_byte;
wire [`SAPC_BYTE_W-1:0] lo_byte;
reg eoc_b_d;
reg acq_d;
reg ref_pwr_d;
reg drive_d;

// ==========================================================
// Pin synchronisers
sapc_sync u_sync_strobe (.mclk(mclk), .rst_b(rst_b),
	.pin(conv_strobe_b), .sync_q(strobe_s));
sapc_sync u_sync_sel (.mclk(mclk), .rst_b(rst_b),
	.pin(read_conv_sel), .sync_q(sel_s));
sapc_sync u_sync_hbs (.mclk(mclk), .rst_b(rst_b),
	.pin(high_byte_select), .sync_q(hbs_s));
sapc_sync u_sync_rst (.mclk(mclk), .rst_b(rst_b),
	.pin(~dev_reset), .sync_q(rst_pin_s));

// Device reset from pin or system
assign soft_rst = !rst_b || !rst_pin_s; // see R4
// A fall counts only after a high level was seen since reset,
// so a strobe held low through a dev_reset starts nothing; the synchroniser resets high on rst_b
assign strobe_fall = strobe_prev_q && !strobe_s;

// Byte split of the held result
assign hi_byte = {`SAPC_HI_PAD, res_q[`SAPC_RES_W-1:`SAPC_BYTE_W]}; // see R9
assign lo_byte = res_q[`SAPC_BYTE_W-1:0];

// ==========================================================
// Next-state logic
always @*
begin
	state_d = state_q;
	case (state_q)
		ST_IDLE:
			if (strobe_fall && !sel_s)
				state_d = ST_ACQ; // see R1
		ST_ACQ:
			if (strobe_fall)
				state_d = ST_CONV; // see R2
		ST_CONV:
			if (cnt_q == CNT_ONE)
				state_d = ST_DONE;
		ST_DONE:
			if (strobe_fall && sel_s)
				state_d = ST_READ; // see R3
			else if (strobe_fall)
				state_d = ST_ACQ; // see R1
		ST_READ:
			if (strobe_s)
				state_d = ST_IDLE;
		default:
			state_d = ST_IDLE;
	endcase
end

// ==========================================================
// Sequencer, SAR and result register
always @(posedge mclk)
begin
	if (soft_rst)
	begin
		// Low so a strobe held low through a dev_reset is no fall
		strobe_prev_q <= 1'b0;
		state_q <= ST_IDLE;
		shut_q <= 1'b0;
		cnt_q <= `SAPC_CNT_ZERO;
		sar_q <= `SAPC_RES_RST;
		bit_q <= `SAPC_RES_RST;
		res_q <= `SAPC_RES_RST;
	end
	else
	begin
		strobe_prev_q <= strobe_s;
		state_q <= state_d;
		if (state_q == ST_ACQ && strobe_fall)
		begin
			shut_q <= sel_s; // see R7
			cnt_q <= CONV_CYC;
			sar_q <= `SAPC_SAR_TOP;
			bit_q <= `SAPC_SAR_TOP;
		end
		else if (state_q == ST_CONV)
		begin
			cnt_q <= cnt_q - CNT_ONE;
			// One trial bit per cycle until all decided
			if (bit_q != `SAPC_RES_RST)
			begin
				sar_q <= (cmp_in ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
				bit_q <= bit_q >> 1;
			end
			if (cnt_q == CNT_ONE)
				res_q <= sar_q; // see R5
		end
	end
end

// ==========================================================
// Output next values from the next state
// Pins are registered from state_d so they move with the state
always @*
begin
	eoc_b_d = 1'b1;
	acq_d = 1'b0;
	ref_pwr_d = ref_pwr_q;
	drive_d = 1'b0;
	case (state_d)
		ST_IDLE:
			// Reference keeps the level the last conversion left
			ref_pwr_d = ref_pwr_q;
		ST_ACQ:
		begin
			// Wake the reference for tracking
			acq_d = 1'b1; // see R1
			ref_pwr_d = 1'b1;
		end
		ST_CONV:
			ref_pwr_d = 1'b1; // see R2
		ST_DONE:
		begin
			// Result ready; shutdown choice drops the reference
			eoc_b_d = 1'b0; // see R8
			if (shut_q)
				ref_pwr_d = 1'b0; // see R7
		end
		ST_READ:
		begin
			// Result stays flagged while the bus is driven
			eoc_b_d = 1'b0; // see R8
			drive_d = 1'b1; // see R3
		end
		default:
		begin
			eoc_b_d = 1'b1;
			acq_d = 1'b0;
		end
	endcase
end

// ==========================================================
// Registered outputs
always @(posedge mclk)
begin
	if (soft_rst)
	begin
		eoc_b_q <= 1'b1;
		ref_pwr_q <= 1'b0;
		acq_q <= 1'b0;
		result_bits_q <= `SAPC_RES_RST;
		result_oe_b_q <= {`SAPC_RES_W{1'b1}};
		byte_bus_q <= {`SAPC_BYTE_W{1'b0}};
		byte_oe_b_q <= {`SAPC_BYTE_W{1'b1}};
	end
	else
	begin
		eoc_b_q <= eoc_b_d; // see R8
		acq_q <= acq_d;
		ref_pwr_q <= ref_pwr_d; // see R7
		result_bits_q <= res_q;
		byte_bus_q <= hbs_s ? hi_byte : lo_byte; // see R6
		// Drive only while presenting a result
		result_oe_b_q <= {`SAPC_RES_W{!drive_d}}; // see R10
		byte_oe_b_q <= {`SAPC_BYTE_W{!drive_d}}; // see R10
	end
end

endmodule
`default_nettype wire

// ==== sapc_chk_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checks
module sapc_chk
(
	// Pins watched
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic dev_reset,
	input wire logic eoc_b_q,
	input wire logic ref_pwr_q,
	input wire logic acq_q,
	input wire logic [13:0] result_oe_b_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b || dev_reset);
	// Conversion runs its full count, then end-of-conversion falls
	sequence s_conv_run;
		##116 eoc_b_q;
	endsequence
	sequence s_done;
		!eoc_b_q;
	endsequence
	a_conv_time: assert property (
		$fell(acq_q) |-> s_conv_run ##1 s_done)
		else $error("conv time");
	a_acq_power: assert property (acq_q |-> ref_pwr_q)
		else $error("acq power");
	a_acq_idle: assert property (acq_q |-> eoc_b_q && &result_oe_b_q)
		else $error("acq bus");
	a_bus_whole: assert property (!result_oe_b_q[0] |->
		!eoc_b_q && result_oe_b_q == 14'h0000)
		else $error("bus drive");
	a_eoc_hold: assert property ($fell(eoc_b_q) |->
		!acq_q ##1 !eoc_b_q [*3])
		else $error("eoc hold");
	a_eoc_rearm: assert property ($rose(eoc_b_q) |->
		acq_q || $rose(result_oe_b_q[0]))
		else $error("eoc rearm");
	a_ref_drop: assert property ($fell(ref_pwr_q) |-> $fell(eoc_b_q))
		else $error("ref drop");
	a_dev_reset: assert property (disable iff (!rst_b)
		dev_reset [*5] |->
		eoc_b_q && !acq_q && !ref_pwr_q && &result_oe_b_q)
		else $error("dev reset");
endmodule
bind sapc_top sapc_chk chk_i(.mclk(mclk), .rst_b(rst_b),
	.dev_reset(dev_reset), .eoc_b_q(eoc_b_q), .ref_pwr_q(ref_pwr_q),
	.acq_q(acq_q), .result_oe_b_q(result_oe_b_q));
`default_nettype wire

// ==== sapc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Host on the strobe port
module sapc_host
(
	// Clock
	input wire logic mclk,
	// Host pins
	output logic strobe_b,
	output logic sel,
	output logic hbs
);
	initial {strobe_b, sel, hbs} = 3'h4;
	// Strobe level with select held through it
	task pin(input logic lvl, input logic s);
		@(posedge mclk);
		#2 strobe_b = lvl;
		sel = s;
		repeat (5) @(posedge mclk);
		#2;
	endtask
	// Byte choice, then settle
	task pick(input logic b);
		@(posedge mclk);
		#2 hbs = b;
		repeat (5) @(posedge mclk);
		#2;
	endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module testbench;
	logic mclk = 0, rst_b = 0, dev_reset = 0, cmp_in = 0;
	wire logic stb_b, sel, hbs, eoc, ref_on, acq;
	wire logic [13:0] res, res_oe;
	wire logic [7:0] bb, bb_oe;
	integer seed = 14, bad_count = 0, checks_done = 0, cyc = 0, i, n, e;
	integer k, r, acc;
	int exp_q[$];
	always #20 mclk = ~mclk;
	sapc_host host(.mclk(mclk), .strobe_b(stb_b), .sel(sel), .hbs(hbs));
	sapc_top uut(.mclk(mclk), .rst_b(rst_b), .dev_reset(dev_reset),
		.conv_strobe_b(stb_b), .read_conv_sel(sel), .high_byte_select(hbs),
		.cmp_in(cmp_in), .eoc_b_q(eoc), .ref_pwr_q(ref_on), .acq_q(acq),
		.result_bits_q(res), .result_oe_b_q(res_oe), .byte_bus_q(bb),
		.byte_oe_b_q(bb_oe));
	// Comparator model: one random decision per trial bit, MSB first
	always @(negedge acq)
	begin
		if (rst_b && !dev_reset)
		begin
			acc = 0;
			for (k = 13; k >= 0; k--)
			begin
				r = $random(seed);
				#2 cmp_in = r[0];
				acc[k] = r[0];
				@(posedge mclk);
			end
			exp_q.push_back(acc);
		end
	end
	// Compare one result
	task chk(input string w, input logic [13:0] x, input logic [13:0] g);
		checks_done++;
		if (g !== x)
		begin
			bad_count++;
			$display("ERROR %s exp %h got %h", w, x, g);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc > 9000)
		begin
			bad_count++;
			test_done;
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		#2 rst_b = 1;
		repeat (4) @(posedge mclk);
		host.pin(0, 1);
		host.pin(1, 1);
		chk("ignored", 0, acq);
		for (i = 0; i < 4; i++)
		begin
			n = $random(seed);
			host.pin(0, 0);
			host.pin(1, 0);
			chk("acq", 1, acq);
			chk("acq ref", 1, ref_on);
			host.pin(0, n[1]);
			host.pin(1, n[1]);
			chk("acq end", 0, acq);
			repeat (150) if (eoc === 1'b1) @(posedge mclk);
			#2;
			chk("eoc", 0, eoc);
			chk("ref", !n[1], ref_on);
			chk("idle oe", 14'h3FFF, res_oe);
			chk("idle boe", 8'hFF, bb_oe);
			chk("model", 1, exp_q.size());
			e = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
			host.pin(0, 1);
			chk("result", e, res);
			chk("oe", 0, res_oe);
			host.pick(1);
			chk("hi byte", {2'h0, e[13:8]}, bb);
			host.pick(0);
			chk("lo byte", e[7:0], bb);
			chk("byte oe", 0, bb_oe);
			host.pin(1, 1);
			chk("release", 14'h3FFF, res_oe);
			chk("byte off", 8'hFF, bb_oe);
		end
		host.pin(0, 0);
		dev_reset = 1;
		repeat (6) @(posedge mclk);
		#2 dev_reset = 0;
		repeat (6) @(posedge mclk);
		#2;
		chk("rst acq", 0, acq);
		chk("rst eoc", 1, eoc);
		chk("rst ref", 0, ref_on);
		chk("rst oe", 14'h3FFF, res_oe);
		host.pin(1, 0);
		host.pin(0, 0);
		chk("rst rearm", 1, acq);
		test_done;
	end
endmodule
`default_nettype wire
